// >>> verilog/bcs_pkg.sv
// shared constants and carrier types for the board config and startup block
package bcs_pkg;
	localparam int NUM_LINES       = 12;
	localparam int NUM_TICKS       = 16;
	localparam int NUM_CORES       = 64;
	localparam int LINE_FANOUT     = 0;
	localparam int LINE_RXP        = 1;
	localparam int LINE_ACC_LO     = 2;
	localparam int LINE_ACC_HI     = 9;
	localparam int LINE_RECIRC     = 10;
	localparam int LINE_ETH        = 11;
	localparam int SEL_LSB         = 0;
	localparam int SEL_W           = 4;
	localparam int VSEL_W          = 6;
	localparam int CLK_PERIOD_NS   = 8;
	localparam int TICK_PERIOD_MS  = 10;
	localparam int TICK_CYCLES     = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
	localparam logic [3:0] SEL_RESET = 4'h0;
	localparam logic [7:0] MONCTL_RESET = 8'h00;

	// monitor and control register image
	typedef struct packed {
		logic       lowVoltOk;
		logic       powerGood;
		logic [1:0] statusLed;
		logic [3:0] tickSelect;
	} bcs_monctl_t;

	// grouped configuration enables, active low on the wire
	typedef struct packed {
		logic       ethernetFpga;
		logic       recirc;
		logic [7:0] accColumn;
		logic       rxp;
		logic       fanout;
	} bcs_cfgen_t;
endpackage

// >>> verilog/bcs_board_config.sv
// board config enable fan-out, done flags, tick generation, tick select, core volt mux
// Contract
// [RQ1] enable line 0 fan-out, 1 rxp, 9:2 acc columns, 10 recirc, 11 ethernet
// [RQ2] host configures fan-out devices before any other group
// [RQ3] host reads group done flag after last bit of a chain
// [RQ4] done flag of 1 means success, anything else is failure
// [RQ5] board ready only when every group done flag is set
// [RQ6] order is fan-out, accumulators, rxp, recirc, ethernet last
// [RQ7] host waits for rxp lock on one low and one high wafer
// [RQ8] continue only if wafers active and 128 MHz clocks unless external
// [RQ9] host waits for each recirc timecode and sample stream lock
// [RQ10] chips started one by one: power, pll reset, then chip reset
// [RQ11] recirc in test generator mode, chips receive mode, then calibrate
// [RQ12] host sets ethernet mode and addresses, then applies all configuration
// [RQ13] locked recirc makes a 10 msec tick aligned to timecode tick bit
// [RQ14] hub takes 16 ticks and forwards one chosen by host write
// [RQ15] chosen tick goes to bridge and interrupts host when enabled
// [RQ16] 64 core voltages muxed to converter channel by select register
// [RQ17] recirc ram test optional, needs temporary bitstream, proves connectivity only
// [RQ18] host asserts enable lines one at a time by writing low
// [RQ19] after low then high pulse, bitstream goes serially lsb first
// [RQ20] select bits 3:0 pick tick source, 000 y0, 001 y1, 100 x0
// [RQ21] host bounds every wait step with a timeout and reports failure
// [RQ22] unlocked recirc holds tick low and emits no partial pulse
`timescale 1ns/1ps
`default_nettype none
module bcs_board_config
	import bcs_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [NUM_LINES-1:0] cfgEnableCtl,
	input  wire logic                 cfgDataBit,
	input  wire logic [NUM_LINES-1:0] groupDone,
	output var  bcs_cfgen_t           cfgEnableLine,
	output logic [NUM_LINES-1:0]      cfgDataOut,
	output logic [NUM_LINES-1:0]      doneStatus,
	output logic                      boardReady,
	input  wire logic [NUM_TICKS-1:0] timecodeLock,
	input  wire logic [NUM_TICKS-1:0] timecodeTickBit,
	output logic [NUM_TICKS-1:0]      tickOut,
	input  wire logic                 monCtlWrite,
	input  wire logic [7:0]           monCtlWdata,
	input  wire logic                 lowVoltOk,
	input  wire logic                 powerGood,
	output var  bcs_monctl_t          monCtl,
	input  wire logic                 irqEnable,
	output logic                      selectedTick,
	output logic                      hostIrq,
	input  wire logic                 vselWrite,
	input  wire logic [VSEL_W-1:0]    vselWdata,
	input  wire logic [NUM_CORES-1:0] coreVoltSense,
	output logic [VSEL_W-1:0]         coreVoltSelect,
	output logic                      adcChannel6
);
	localparam int CW = $clog2(TICK_LEN + 1);

	logic [NUM_LINES-1:0] cfgEnable;
	logic [NUM_LINES-1:0] next_cfgEnable;
	logic [NUM_LINES-1:0] next_cfgDataOut;
	logic [NUM_LINES-1:0] next_doneStatus;
	logic                 next_boardReady;
	logic [3:0]           tickSel;
	logic [3:0]           next_tickSel;
	logic [1:0]           ledState;
	logic [1:0]           next_ledState;
	logic                 next_selectedTick;
	logic [VSEL_W-1:0]    next_coreVoltSelect;
	logic                 next_adcChannel6;

	// enable lines pass as registered levels; the host owns ordering and one-hot use
	always_comb begin
		next_cfgEnable = cfgEnableCtl; // RQ18
		next_doneStatus = groupDone;
		next_boardReady = &groupDone; // RQ5
		// data follows only released (high) enables; a chain held in program enable sees zero
		for (int i = 0; i < NUM_LINES; i++) begin
			next_cfgDataOut[i] = cfgDataBit & cfgEnableCtl[i]; // RQ19
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfgEnable  <= '1;
			cfgDataOut <= '0;
			doneStatus <= '0;
			boardReady <= 1'b0;
		end else begin
			cfgEnable  <= next_cfgEnable;
			cfgDataOut <= next_cfgDataOut;
			doneStatus <= next_doneStatus; // RQ4
			boardReady <= next_boardReady;
		end
	end

	// group mapping of the enable lines
	assign cfgEnableLine.fanout       = cfgEnable[LINE_FANOUT]; // RQ1
	assign cfgEnableLine.rxp          = cfgEnable[LINE_RXP];
	assign cfgEnableLine.accColumn    = cfgEnable[LINE_ACC_HI:LINE_ACC_LO];
	assign cfgEnableLine.recirc       = cfgEnable[LINE_RECIRC];
	assign cfgEnableLine.ethernetFpga = cfgEnable[LINE_ETH];

	// one tick generator per recirc controller
	generate
		for (genvar g = 0; g < NUM_TICKS; g++) begin : gTick
			logic [CW-1:0] cnt;
			logic [CW-1:0] next_cnt;
			logic          run;
			logic          next_run;
			logic          next_tick;
			always_comb begin
				next_cnt = cnt;
				next_run = run;
				next_tick = 1'b0;
				if (!timecodeLock[g]) begin
					// losing lock drops the tick at once, nothing half-formed escapes
					next_run = 1'b0; // RQ22
					next_cnt = '0;
				end else if (timecodeTickBit[g]) begin
					// every tick bit realigns the phase
					next_run = 1'b1; // RQ13
					next_cnt = '0;
					next_tick = 1'b1;
				end else if (run) begin
					if (cnt == CW'(TICK_LEN - 1)) begin
						next_cnt = '0;
						next_tick = 1'b1; // RQ13
					end else begin
						next_cnt = cnt + 1'b1;
					end
				end
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cnt        <= '0;
					run        <= 1'b0;
					tickOut[g] <= 1'b0;
				end else begin
					cnt        <= next_cnt;
					run        <= next_run;
					tickOut[g] <= next_tick;
				end
			end
		end
	endgenerate

	// hub register and tick selection; the code is the lane index: 0 is y0, 1 is y1, 4 is x0
	always_comb begin
		next_tickSel = tickSel;
		next_ledState = ledState;
		if (monCtlWrite) begin
			next_tickSel = monCtlWdata[SEL_LSB +: SEL_W]; // RQ20
			next_ledState = monCtlWdata[5:4];
		end
		next_selectedTick = tickOut[tickSel]; // RQ14
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tickSel      <= SEL_RESET;
			ledState     <= MONCTL_RESET[5:4];
			selectedTick <= 1'b0;
		end else begin
			tickSel      <= next_tickSel;
			ledState     <= next_ledState;
			selectedTick <= next_selectedTick;
		end
	end

	assign monCtl.lowVoltOk  = lowVoltOk;
	assign monCtl.powerGood  = powerGood;
	assign monCtl.statusLed  = ledState;
	assign monCtl.tickSelect = tickSel;
	// bridge gating of the forwarded tick
	assign hostIrq = selectedTick & irqEnable; // RQ15

	// core voltage select register and analog mux model
	always_comb begin
		next_coreVoltSelect = coreVoltSelect;
		if (vselWrite) begin
			next_coreVoltSelect = vselWdata; // RQ16
		end
		next_adcChannel6 = coreVoltSense[coreVoltSelect]; // RQ16
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			coreVoltSelect <= '0;
			adcChannel6    <= 1'b0;
		end else begin
			coreVoltSelect <= next_coreVoltSelect;
			adcChannel6    <= next_adcChannel6;
		end
	end
endmodule // bcs_board_config
`default_nettype wire

// >>> dv/bcs_timecode_src.sv
// stand-in timecode source: tick bit for every controller
`timescale 1ns/1ps
`default_nettype none
module bcs_timecode_src (
	input  wire logic        go,
	output logic [15:0]      tickBit
);
	// one tick bit on all lines per go cycle; lock is driven apart
	assign tickBit = {16{go}};
endmodule // bcs_timecode_src
`default_nettype wire

// >>> dv/bcs_board_config_chk.sv
// assertions on the board config ports
`timescale 1ns/1ps
`default_nettype none
module bcs_board_config_chk
	import bcs_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [11:0] cfgEnableCtl,
	input wire logic [11:0] groupDone,
	input wire bcs_cfgen_t  cfgEnableLine,
	input wire logic        boardReady,
	input wire logic [15:0] timecodeLock,
	input wire logic [15:0] timecodeTickBit,
	input wire logic [15:0] tickOut,
	input wire logic        monCtlWrite,
	input wire logic [7:0]  monCtlWdata,
	input wire bcs_monctl_t monCtl,
	input wire logic        irqEnable,
	input wire logic        selectedTick,
	input wire logic        hostIrq,
	input wire logic [63:0] coreVoltSense,
	input wire logic [5:0]  coreVoltSelect,
	input wire logic        adcChannel6
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_lines; 1'b1 |=> cfgEnableLine.accColumn == $past(cfgEnableCtl[9:2])
		&& cfgEnableLine.fanout == $past(cfgEnableCtl[0]); endproperty
	a_lines: assert property (p_lines) else $error("enable line map");
	property p_ready; 1'b1 |=> boardReady == &$past(groupDone); endproperty
	a_ready: assert property (p_ready) else $error("board ready");
	property p_unlock; !timecodeLock[0] |=> !tickOut[0]; endproperty
	a_unlock: assert property (p_unlock) else $error("tick while unlocked");
	property p_align; timecodeLock[1] && timecodeTickBit[1] |=> tickOut[1]; endproperty
	a_align: assert property (p_align) else $error("tick not aligned");
	property p_sel; monCtlWrite |=> monCtl.tickSelect == $past(monCtlWdata[3:0]); endproperty
	a_sel: assert property (p_sel) else $error("tick select");
	property p_route; 1'b1 |=> selectedTick == $past(tickOut[monCtl.tickSelect]); endproperty
	a_route: assert property (p_route) else $error("tick routing");
	property p_irq; hostIrq == (selectedTick && irqEnable); endproperty
	a_irq: assert property (p_irq) else $error("host interrupt");
	property p_adc; 1'b1 |=> adcChannel6 == $past(coreVoltSense[coreVoltSelect]); endproperty
	a_adc: assert property (p_adc) else $error("core voltage mux");
endmodule // bcs_board_config_chk
bind bcs_board_config bcs_board_config_chk chk_i (
	.clk            (clk),
	.rst            (rst),
	.cfgEnableCtl   (cfgEnableCtl),
	.groupDone      (groupDone),
	.cfgEnableLine  (cfgEnableLine),
	.boardReady     (boardReady),
	.timecodeLock   (timecodeLock),
	.timecodeTickBit(timecodeTickBit),
	.tickOut        (tickOut),
	.monCtlWrite    (monCtlWrite),
	.monCtlWdata    (monCtlWdata),
	.monCtl         (monCtl),
	.irqEnable      (irqEnable),
	.selectedTick   (selectedTick),
	.hostIrq        (hostIrq),
	.coreVoltSense  (coreVoltSense),
	.coreVoltSelect (coreVoltSelect),
	.adcChannel6    (adcChannel6)
);
`default_nettype wire

// >>> dv/tb_board_config_startup_sequencer.sv
// self-checking bench for the board config block
`timescale 1ns/1ps
`default_nettype none
module tb_board_config_startup_sequencer
	import bcs_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, cfgDataBit = 1'b0, lowVoltOk = 1'b1, powerGood = 1'b1;
	logic monCtlWrite = 1'b0, irqEnable = 1'b1, vselWrite = 1'b0, go = 1'b0;
	logic boardReady, selectedTick, hostIrq, adcChannel6;
	logic [11:0] cfgEnableCtl = 12'hfff, groupDone = 12'h000, cfgDataOut, doneStatus;
	logic [15:0] timecodeLock = 16'h0000, timecodeTickBit, tickOut;
	logic [7:0] monCtlWdata = 8'h00;
	logic [5:0] vselWdata = 6'h00, coreVoltSelect;
	logic [63:0] coreVoltSense = 64'h8000_0400_0000_0000;
	bcs_cfgen_t cfgEnableLine;
	bcs_monctl_t monCtl;
	int err_count = 0, comparisons = 0, n;
	// rows: one enable low at a time in bring-up order, done flags, expected ready
	logic [24:0] rows [5] = '{{12'hffe, 12'h001, 1'b0}, {12'hdff, 12'h3fd, 1'b0},
		{12'hffd, 12'h3ff, 1'b0}, {12'hbff, 12'hffe, 1'b0},
		{12'h7ff, 12'hfff, 1'b1}};
	logic [3:0] codes [3] = '{4'h0, 4'h1, 4'h4};
	logic [5:0] vals [3] = '{6'h2a, 6'h3f, 6'h00};
	always #4 clk = ~clk;
	// short tick period keeps the run brief
	bcs_board_config #(.TICK_LEN(20)) dut (
		.clk            (clk),
		.rst            (rst),
		.cfgEnableCtl   (cfgEnableCtl),
		.cfgDataBit     (cfgDataBit),
		.groupDone      (groupDone),
		.cfgEnableLine  (cfgEnableLine),
		.cfgDataOut     (cfgDataOut),
		.doneStatus     (doneStatus),
		.boardReady     (boardReady),
		.timecodeLock   (timecodeLock),
		.timecodeTickBit(timecodeTickBit),
		.tickOut        (tickOut),
		.monCtlWrite    (monCtlWrite),
		.monCtlWdata    (monCtlWdata),
		.lowVoltOk      (lowVoltOk),
		.powerGood      (powerGood),
		.monCtl         (monCtl),
		.irqEnable      (irqEnable),
		.selectedTick   (selectedTick),
		.hostIrq        (hostIrq),
		.vselWrite      (vselWrite),
		.vselWdata      (vselWdata),
		.coreVoltSense  (coreVoltSense),
		.coreVoltSelect (coreVoltSelect),
		.adcChannel6    (adcChannel6)
	);
	bcs_timecode_src tcs (.go(go), .tickBit(timecodeTickBit));
	task automatic step(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		step(12);
		chk("linesInReset", 12'hfff, cfgEnableLine);
		chk("readyInReset", 0, boardReady);
		rst = 1'b0;
		$display("reset test done");
		foreach (rows[i]) begin
			{cfgEnableCtl, groupDone} = rows[i][24:1];
			cfgDataBit = ~i[0];
			step(2);
			chk("cfgEnableLine", cfgEnableCtl, cfgEnableLine);
			chk("cfgDataOut", {12{cfgDataBit}} & cfgEnableCtl, cfgDataOut);
			chk("boardReady", rows[i][0], boardReady);
			chk("doneStatus", groupDone, doneStatus);
		end
		$display("row test done");
		go = 1'b1;
		step(1);
		go = 1'b0;
		step(1);
		chk("tickUnlocked", 0, tickOut);
		foreach (codes[i]) begin
			monCtlWdata = {4'(i + 1), codes[i]};
			monCtlWrite = 1'b1;
			timecodeLock = 16'h0001 << codes[i];
			irqEnable = ~i[0];
			lowVoltOk = i[0];
			powerGood = ~i[0];
			step(1);
			chk("monCtl", {lowVoltOk, powerGood, monCtlWdata[5:0]}, monCtl);
			monCtlWrite = 1'b0;
			go = 1'b1;
			step(1);
			go = 1'b0;
			chk("tickOut", timecodeLock, tickOut);
			step(1);
			chk("selectedTick", 1, selectedTick);
			chk("hostIrq", irqEnable, hostIrq);
			// a tick that never comes ends the wait after 39 cycles
			for (n = 1; tickOut[codes[i]] !== 1'b1 && n < 40; n++)
				step(1);
			chk("tickPeriod", 20, n);
		end
		$display("tick test done");
		foreach (vals[i]) begin
			vselWdata = vals[i];
			vselWrite = 1'b1;
			step(1);
			vselWrite = 1'b0;
			chk("coreVoltSelect", vselWdata, coreVoltSelect);
			step(1);
			chk("adcChannel6", coreVoltSense[vselWdata], adcChannel6);
		end
		$display("voltage select test done");
		// reset in mid-run must drop every registered output to its idle value
		rst = 1'b1;
		step(1);
		chk("linesMidReset", 12'hfff, cfgEnableLine);
		chk("readyMidReset", 0, boardReady);
		chk("voltMidReset", 0, {coreVoltSelect, adcChannel6});
		chk("selMidReset", 0, monCtl.tickSelect);
		chk("tickMidReset", 0, tickOut);
		rst = 1'b0;
		step(2);
		chk("readyAfterReset", 1, boardReady);
		chk("linesAfterReset", cfgEnableCtl, cfgEnableLine);
		$display("mid-run reset test done");
		give_verdict();
	end
	// some 100 cycles are expected, so 20 us leaves wide margin
	initial begin
		#20000;
		err_count++;
		give_verdict();
	end
endmodule // tb_board_config_startup_sequencer
`default_nettype wire
